// [src/ppmc_pkg.sv]
package ppmc_pkg;

   // Register addresses in the direct register space
   localparam logic [7:0] PPMC_ADDR_CTRL_HIGH   = 8'hC6;
   localparam logic [7:0] PPMC_ADDR_CTRL_MIDDLE = 8'hC7;
   localparam logic [7:0] PPMC_ADDR_CTRL_LOW    = 8'hC8;

   // Reset values
   localparam logic [7:0] PPMC_RST_CTRL_HIGH    = 8'h01;
   localparam logic [7:0] PPMC_RST_CTRL_MIDDLE  = 8'h00;
   localparam logic [7:0] PPMC_RST_CTRL_LOW     = 8'h10;

   // Implemented bits of each control register, others read zero
   localparam logic [7:0] PPMC_MASK_CTRL_HIGH   = 8'hEF;
   localparam logic [7:0] PPMC_MASK_CTRL_MIDDLE = 8'hE3;
   localparam logic [7:0] PPMC_MASK_CTRL_LOW    = 8'h3F;

   // Field positions (low bit of each mode field)
   localparam int PPMC_POS_PIN7 = 5;
   localparam int PPMC_POS_PIN6 = 2;
   localparam int PPMC_POS_PIN5 = 0;
   localparam int PPMC_POS_PIN4 = 5;
   localparam int PPMC_POS_PIN3 = 0;
   localparam int PPMC_POS_PIN2 = 4;
   localparam int PPMC_POS_PIN1 = 2;
   localparam int PPMC_POS_PIN0 = 0;

   // Three-bit mode codes; two-bit fields are widened onto these
   localparam logic [2:0] PPMC_CODE_INPUT   = 3'h0;
   localparam logic [2:0] PPMC_CODE_OPEN    = 3'h1;
   localparam logic [2:0] PPMC_CODE_ANALOG  = 3'h2;
   localparam logic [2:0] PPMC_CODE_SPECIAL = 3'h3;
   localparam logic [2:0] PPMC_CODE_PUSH    = 3'h4;

   // Option field values
   localparam logic [2:0] PPMC_OSC_CRYSTAL  = 3'h7;
   localparam logic [2:0] PPMC_OSC_RC_FIRST = 3'h1;
   localparam logic [2:0] PPMC_OSC_RC_LAST  = 3'h4;

   // Pin numbers with fixed roles
   localparam int PPMC_PIN_RESET = 3;
   localparam int PPMC_PIN_PWM   = 4;
   localparam int PPMC_PIN_VREF  = 7;

   typedef enum logic [2:0] {
      PPMC_KIND_INPUT,
      PPMC_KIND_OPEN,
      PPMC_KIND_PUSH,
      PPMC_KIND_ANALOG,
      PPMC_KIND_SPECIAL
   } ppmc_kind_type;

   // Control register set
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] middle;
      logic [7:0] low;
   } ppmc_ctrl_type;

   // Pad drive of all eight pins
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } ppmc_drive_type;

endpackage : ppmc_pkg

// [src/ppmc_top.sv]
// Operation
// - Pin 7 mode field picks 000 input, 001 open-drain, 010 analog 7, 011 reference, 1xx push-pull.
// - Pin 6 field picks 00 input, 01 open-drain, 10 analog 6, 11 push-pull.
// - Pin 5 field picks 00 input, 01 open-drain, 10 analog 5, 11 push-pull.
// - Pin 4 field picks 000 input, 001 open-drain, 010 analog 4, 011 PWM/timer out, 1xx push-pull.
// - Pin 2 field picks 00 input, 01 open-drain, 10 analog 2, 11 push-pull.
// - Pins 1 and 0 fields pick 00 input, 01 open-drain, 10 analog 1/0, 11 push-pull.
// - Pin 3 is the reset input when the low-voltage option bit is 1, a port pin when 0.
// - Pins 0 and 1 are crystal pins for oscillator option 111 and port pins for 001 to 100.
// - The processor reaches the port only by direct reads and writes of its registers.
`timescale 1ns/1ps

module ppmc_top
   import ppmc_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Direct register access
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // Port data and peripheral sources
   input  wire logic [7:0] port_data,
   input  wire logic       pwm_out,
   // Factory options
   input  wire logic       low_voltage_reset_option,
   input  wire logic [2:0] oscillator_select_option,
   // Pads
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe_n,
   // Peripheral side
   output logic      [7:0] port_in_level,
   output logic      [7:0] analog_sel,
   output logic            vref_sel,
   output logic            pwm_pin_sel,
   output logic            timer3_count_clock,
   output logic            timer2_count_clock,
   output logic            ext_irq_2,
   output logic            ext_irq_1,
   output logic            ext_irq_0,
   output logic            external_reset_in,
   output logic            osc_pins_crystal
);

   // Widen a two-bit field onto the three-bit code space
   function automatic logic [2:0] ppmc_widen(input logic [1:0] field);
      logic [2:0] code;
      code = {1'b0, field};
      if (field == 2'h3) begin
         code = PPMC_CODE_PUSH;
      end
      return code;
   endfunction : ppmc_widen

   // Classify a three-bit code
   function automatic ppmc_kind_type ppmc_decode(input logic [2:0] code);
      ppmc_kind_type kind;
      kind = PPMC_KIND_INPUT;
      if (code[2]) begin
         kind = PPMC_KIND_PUSH;
      end else begin
         case (code[1:0])
            2'h0:    kind = PPMC_KIND_INPUT;
            2'h1:    kind = PPMC_KIND_OPEN;
            2'h2:    kind = PPMC_KIND_ANALOG;
            2'h3:    kind = PPMC_KIND_SPECIAL;
            default: kind = PPMC_KIND_INPUT;
         endcase
      end
      return kind;
   endfunction : ppmc_decode

   ppmc_ctrl_type  ctrl;
   ppmc_ctrl_type  next_ctrl;
   logic [7:0]     next_reg_rdata;
   logic           next_reg_rvalid;
   logic [7:0]     pin_sync1;
   logic [7:0]     pin_sync2;
   logic [1:0]     opt_lvr_sync;
   logic [2:0]     opt_osc_sync1;
   logic [2:0]     opt_osc_sync2;
   logic [2:0]     pin_code [8];
   ppmc_kind_type  pin_kind [8];
   ppmc_drive_type drive;
   ppmc_drive_type next_drive;
   logic [7:0]     next_port_in_level;
   logic [7:0]     next_analog_sel;
   logic           next_vref_sel;
   logic           next_pwm_pin_sel;
   logic           next_external_reset_in;
   logic           next_osc_pins_crystal;
   logic           reset_pin_mode;
   logic           crystal_mode;
   logic           rc_mode;
   logic [7:0]     released;

   // Register write and read back; one access per cycle, no indirection
   always_comb begin
      next_ctrl       = ctrl;
      next_reg_rdata  = reg_rdata;
      next_reg_rvalid = reg_rd;
      if (reg_wr) begin
         case (reg_addr)
            PPMC_ADDR_CTRL_HIGH:   next_ctrl.high   = reg_wdata & PPMC_MASK_CTRL_HIGH;
            PPMC_ADDR_CTRL_MIDDLE: next_ctrl.middle = reg_wdata & PPMC_MASK_CTRL_MIDDLE;
            PPMC_ADDR_CTRL_LOW:    next_ctrl.low    = reg_wdata & PPMC_MASK_CTRL_LOW;
            default:               next_ctrl        = ctrl;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            PPMC_ADDR_CTRL_HIGH:   next_reg_rdata = ctrl.high;
            PPMC_ADDR_CTRL_MIDDLE: next_reg_rdata = ctrl.middle;
            PPMC_ADDR_CTRL_LOW:    next_reg_rdata = ctrl.low;
            default:               next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl.high   <= PPMC_RST_CTRL_HIGH;
         ctrl.middle <= PPMC_RST_CTRL_MIDDLE;
         ctrl.low    <= PPMC_RST_CTRL_LOW;
         reg_rdata   <= 8'h00;
         reg_rvalid  <= 1'b0;
      end else begin
         ctrl       <= next_ctrl;
         reg_rdata  <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // Pads and option straps are asynchronous: two flops before any use
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_sync1     <= 8'h00;
         pin_sync2     <= 8'h00;
         opt_lvr_sync  <= 2'h0;
         opt_osc_sync1 <= 3'h0;
         opt_osc_sync2 <= 3'h0;
      end else begin
         pin_sync1     <= pin_in;
         pin_sync2     <= pin_sync1;
         opt_lvr_sync  <= {opt_lvr_sync[0], low_voltage_reset_option};
         opt_osc_sync1 <= oscillator_select_option;
         opt_osc_sync2 <= opt_osc_sync1;
      end
   end

   // Mode codes per pin
   assign pin_code[7] = ctrl.high[PPMC_POS_PIN7 +: 3];
   assign pin_code[6] = ppmc_widen(ctrl.high[PPMC_POS_PIN6 +: 2]);
   assign pin_code[5] = ppmc_widen(ctrl.high[PPMC_POS_PIN5 +: 2]);
   assign pin_code[4] = ctrl.middle[PPMC_POS_PIN4 +: 3];
   // Unused pin 3 codes fall back to input, so the pad never drives by mistake
   assign pin_code[3] = ctrl.middle[PPMC_POS_PIN3 + 1] ? PPMC_CODE_INPUT :
                        {2'h0, ctrl.middle[PPMC_POS_PIN3]};
   assign pin_code[2] = ppmc_widen(ctrl.low[PPMC_POS_PIN2 +: 2]);
   assign pin_code[1] = ppmc_widen(ctrl.low[PPMC_POS_PIN1 +: 2]);
   assign pin_code[0] = ppmc_widen(ctrl.low[PPMC_POS_PIN0 +: 2]);

   // Option decode; an undefined oscillator choice also takes pins 0 and 1 off the port
   assign reset_pin_mode = opt_lvr_sync[1];
   assign crystal_mode   = (opt_osc_sync2 == PPMC_OSC_CRYSTAL);
   assign rc_mode        = (opt_osc_sync2 >= PPMC_OSC_RC_FIRST) &&
                           (opt_osc_sync2 <= PPMC_OSC_RC_LAST);
   assign released = {4'h0, reset_pin_mode, 1'b0, {2{~rc_mode}}};

   // Per-pin pad drive and input qualification
   generate
      for (genvar i = 0; i < 8; i++) begin : g_pin
         assign pin_kind[i] = ppmc_decode(pin_code[i]);
         always_comb begin
            next_drive.out[i]     = 1'b0;
            next_drive.oe_n[i]    = 1'b1;
            next_port_in_level[i] = 1'b0;
            next_analog_sel[i]    = 1'b0;
            if (!released[i]) begin
               case (pin_kind[i])
                  PPMC_KIND_INPUT: begin
                     next_port_in_level[i] = pin_sync2[i];
                  end
                  PPMC_KIND_OPEN: begin
                     // Drive only a low; a one lets the line float up
                     next_drive.oe_n[i] = port_data[i];
                  end
                  PPMC_KIND_PUSH: begin
                     next_drive.out[i]  = port_data[i];
                     next_drive.oe_n[i] = 1'b0;
                  end
                  PPMC_KIND_ANALOG: begin
                     next_analog_sel[i] = 1'b1;
                  end
                  PPMC_KIND_SPECIAL: begin
                     // Pad follows the PWM only on its own pin; no peripheral enable gates it
                     if (i == PPMC_PIN_PWM) begin
                        next_drive.out[i]  = pwm_out;
                        next_drive.oe_n[i] = 1'b0;
                     end
                  end
                  default: begin
                     next_drive.oe_n[i] = 1'b1;
                  end
               endcase
            end
         end
      end
   endgenerate

   // Special functions and option-owned pins
   always_comb begin
      next_vref_sel          = !released[PPMC_PIN_VREF] &&
                               (pin_kind[PPMC_PIN_VREF] == PPMC_KIND_SPECIAL);
      next_pwm_pin_sel       = !released[PPMC_PIN_PWM] &&
                               (pin_kind[PPMC_PIN_PWM] == PPMC_KIND_SPECIAL);
      next_external_reset_in = reset_pin_mode & pin_sync2[PPMC_PIN_RESET];
      next_osc_pins_crystal  = crystal_mode;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         drive.out          <= 8'h00;
         drive.oe_n         <= 8'hFF;
         port_in_level      <= 8'h00;
         analog_sel         <= 8'h00;
         vref_sel           <= 1'b0;
         pwm_pin_sel        <= 1'b0;
         external_reset_in  <= 1'b0;
         osc_pins_crystal   <= 1'b0;
         timer3_count_clock <= 1'b0;
         timer2_count_clock <= 1'b0;
         ext_irq_2          <= 1'b0;
         ext_irq_1          <= 1'b0;
         ext_irq_0          <= 1'b0;
      end else begin
         drive              <= next_drive;
         port_in_level      <= next_port_in_level;
         analog_sel         <= next_analog_sel;
         vref_sel           <= next_vref_sel;
         pwm_pin_sel        <= next_pwm_pin_sel;
         external_reset_in  <= next_external_reset_in;
         osc_pins_crystal   <= next_osc_pins_crystal;
         // Counter clocks and interrupts share the input-mode samples
         timer3_count_clock <= next_port_in_level[7];
         ext_irq_2          <= next_port_in_level[7];
         timer2_count_clock <= next_port_in_level[6];
         ext_irq_1          <= next_port_in_level[6];
         ext_irq_0          <= next_port_in_level[4];
      end
   end

   assign pin_out  = drive.out;
   assign pin_oe_n = drive.oe_n;

endmodule : ppmc_top

// [verif/ppmc_asserts.sv]
`timescale 1ns/1ps
module ppmc_asserts
   import ppmc_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       sys_rst,
   // Register access
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // Sources and straps
   input wire logic [7:0] port_data,
   input wire logic       pwm_out,
   input wire logic       low_voltage_reset_option,
   input wire logic [2:0] oscillator_select_option,
   // Pads and peripheral side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] port_in_level,
   input wire logic [7:0] analog_sel,
   input wire logic       vref_sel,
   input wire logic       pwm_pin_sel,
   input wire logic       ext_irq_2,
   input wire logic       ext_irq_0,
   input wire logic       external_reset_in,
   input wire logic       osc_pins_crystal
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // Write of a pin 7 code, then a quiet cycle so the field settles
   sequence wr_hi(logic [2:0] c);
      reg_wr && reg_addr == PPMC_ADDR_CTRL_HIGH && reg_wdata[7:5] == c;
   endsequence
   sequence quiet_hi;
      !(reg_wr && reg_addr == PPMC_ADDR_CTRL_HIGH);
   endsequence

   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   chk_valid_pulse: assert property (!reg_rd |=> !reg_rvalid)
      else $error("stray read valid");
   chk_unmapped_read: assert property (reg_rd && (reg_addr < PPMC_ADDR_CTRL_HIGH ||
      reg_addr > PPMC_ADDR_CTRL_LOW) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_push_pin7: assert property (wr_hi(3'h4) ##1 quiet_hi |=>
      !pin_oe_n[7] && pin_out[7] == $past(port_data[7]))
      else $error("pin 7 push-pull wrong");
   chk_vref_pin7: assert property (wr_hi(3'h3) ##1 quiet_hi |=>
      vref_sel && pin_oe_n[7] && !analog_sel[7])
      else $error("pin 7 reference wrong");
   chk_pwm_drive: assert property (pwm_pin_sel |->
      !pin_oe_n[4] && pin_out[4] == $past(pwm_out))
      else $error("pin 4 timer output wrong");
   chk_pin3_digital: assert property (!analog_sel[3])
      else $error("pin 3 analog");
   chk_irq_map: assert property (ext_irq_2 == port_in_level[7] &&
      ext_irq_0 == port_in_level[4])
      else $error("interrupt level map wrong");
   chk_reset_pin: assert property (low_voltage_reset_option [*5] |-> pin_oe_n[3])
      else $error("pin 3 driven in reset mode");
   chk_no_reset_in: assert property (!low_voltage_reset_option [*5] |->
      !external_reset_in)
      else $error("reset input while port pin");
   chk_crystal: assert property ((oscillator_select_option == PPMC_OSC_CRYSTAL) [*5] |->
      osc_pins_crystal && (&pin_oe_n[1:0]))
      else $error("crystal pins driven");
endmodule : ppmc_asserts

bind ppmc_top ppmc_asserts ppmc_asserts_inst (.*);

// [verif/ppmc_pad_model.sv]
`timescale 1ns/1ps
module ppmc_pad_model
   import ppmc_pkg::*;
(
   // Pad drive from the block
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   // Board levels on released pads
   input  wire logic [7:0] board_lvl,
   // Resolved pad levels
   output logic      [7:0] pin_in
);
   // Released pads follow the board, so a stuck driver shows up
   always_comb begin
      pin_in = (pin_out & ~pin_oe_n) | (board_lvl & pin_oe_n);
   end
endmodule : ppmc_pad_model

// [verif/ppmc_top_tb.sv]
`timescale 1ns/1ps
module ppmc_top_tb
   import ppmc_pkg::*;
;
   logic       core_clk, sys_rst, reg_wr, reg_rd, pwm_out, reg_rvalid;
   logic       low_voltage_reset_option, vref_sel, pwm_pin_sel, ext_irq_1;
   logic       timer3_count_clock, timer2_count_clock, ext_irq_2, ext_irq_0;
   logic       external_reset_in, osc_pins_crystal;
   logic [2:0] oscillator_select_option;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, port_data, pin_in, pin_out;
   logic [7:0] pin_oe_n, port_in_level, analog_sel, board_lvl;
   int         n_mismatch = 0, samples_checked = 0, cycles = 0;

   ppmc_top ppmc_top_inst (.*);
   ppmc_pad_model ppmc_pad_model_inst (.*);

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Hang guard, far above the few hundred cycles needed
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read answer lands one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, exp);
      cmp({7'h00, reg_rvalid}, 8'h01);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle

   // Expected {oe_n, out, analog}; sp marks the timer output pin
   function automatic logic [2:0] exp_pad(input logic [2:0] c, input logic d, input logic sp);
      case (c)
         3'h0: return 3'b100;
         3'h1: return {d, 2'b00};
         3'h2: return 3'b101;
         3'h3: return sp ? {1'b0, ~d, 1'b0} : 3'b100;
         default: return {1'b0, d, 1'b0};
      endcase
   endfunction : exp_pad

   // Reset values, unused bits and two unmapped places
   task automatic t_regs();
      rd(8'hC6, 8'h01);
      rd(8'hC7, 8'h00);
      rd(8'hC8, 8'h10);
      rd(8'hC5, 8'h00);
      for (int i = 0; i < 4; i++)
         wr(8'(8'hC6 + i), 8'hFF);
      rd(8'hC6, 8'hEF);
      rd(8'hC7, 8'hE3);
      rd(8'hC8, 8'h3F);
      rd(8'hC9, 8'h00);
   endtask : t_regs

   // Every code of one field; pwm held opposite to the data bit
   task automatic t_field(input int p, input logic [7:0] a, input int pos, input int n,
                          input logic f);
      logic [2:0] c;
      logic [2:0] e;
      logic       d;
      for (int i = 0; i < n; i++) begin
         c = 3'(i);
         d = c[1] ^ f;
         e = (n == 4 && c == 3'h3) ? 3'h4 : c;
         if (p == PPMC_PIN_RESET && c[1])
            e = 3'h0;
         @(posedge core_clk);
         port_data <= {8{d}};
         pwm_out <= ~d;
         wr(a, 8'(i << pos));
         settle(2);
         cmp({3'h0, pwm_pin_sel, vref_sel, pin_oe_n[p], pin_out[p] & ~pin_oe_n[p],
              analog_sel[p]},
             {3'h0, p == PPMC_PIN_PWM && c == 3'h3, p == PPMC_PIN_VREF && c == 3'h3,
              exp_pad(e, d, p == PPMC_PIN_PWM)});
      end
   endtask : t_field

   task automatic t_modes();
      t_field(7, 8'hC6, 5, 8, 1'b0);
      t_field(6, 8'hC6, 2, 4, 1'b1);
      t_field(5, 8'hC6, 0, 4, 1'b0);
      t_field(4, 8'hC7, 5, 8, 1'b1);
      t_field(3, 8'hC7, 0, 4, 1'b0);
      t_field(2, 8'hC8, 4, 4, 1'b1);
      t_field(1, 8'hC8, 2, 4, 1'b0);
      t_field(0, 8'hC8, 0, 4, 1'b1);
   endtask : t_modes

   // All pins input; levels reach the peripheral side in three edges
   task automatic t_input(input logic [7:0] v);
      logic [7:0] q;
      wr(8'hC6, 8'h00);
      wr(8'hC7, 8'h00);
      wr(8'hC8, 8'h00);
      board_lvl <= v;
      settle(4);
      q = {3'h0, ext_irq_2, timer3_count_clock, ext_irq_1, timer2_count_clock, ext_irq_0};
      cmp(port_in_level, v);
      cmp(q, {3'h0, v[7], v[7], v[6], v[6], v[4]});
   endtask : t_input

   // Reset pin and crystal pins claimed by the straps
   task automatic t_straps();
      port_data <= 8'h00;
      wr(8'hC7, 8'h01);
      wr(8'hC8, 8'h0F);
      board_lvl <= 8'h08;
      low_voltage_reset_option <= 1'b1;
      oscillator_select_option <= PPMC_OSC_CRYSTAL;
      settle(6);
      cmp({4'h0, external_reset_in, pin_oe_n[3], osc_pins_crystal, &pin_oe_n[1:0]},
          8'h0F);
      low_voltage_reset_option <= 1'b0;
      oscillator_select_option <= PPMC_OSC_RC_LAST;
      settle(6);
      cmp({4'h0, external_reset_in, pin_oe_n[3], osc_pins_crystal, |pin_oe_n[1:0]},
          8'h00);
   endtask : t_straps

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, pwm_out, low_voltage_reset_option} = 4'h0;
      {reg_addr, reg_wdata, port_data, board_lvl} = 32'h0;
      oscillator_select_option = PPMC_OSC_RC_FIRST;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_modes();
      t_input(8'hD1);
      t_input(8'h2E);
      t_straps();
      give_verdict();
   end
endmodule : ppmc_top_tb
